/* inc/mfos_pkg.sv */
// constants for the multi-function output selector
package mfos_pkg;

    // function codes of output_function_select
    localparam logic [7:0] FC_RUNNING = 8'h00;
    localparam logic [7:0] FC_FAULT = 8'h01;
    localparam logic [7:0] FC_FREQ_AGREE = 8'h02;
    localparam logic [7:0] FC_SET_AGREE = 8'h03;
    localparam logic [7:0] FC_FDET1 = 8'h04;
    localparam logic [7:0] FC_FDET2 = 8'h05;
    localparam logic [7:0] FC_RESTART = 8'h06;
    localparam logic [7:0] FC_OUT_BLOCK = 8'h09;
    localparam logic [7:0] FC_OVER_TORQUE = 8'h0c;
    localparam logic [7:0] FC_CUR_AGREE = 8'h0d;
    localparam logic [7:0] FC_ZERO_SPEED = 8'h14;
    localparam logic [7:0] FC_READY = 8'h15;
    localparam logic [7:0] FC_UNDERVOLT = 8'h16;
    localparam logic [7:0] FC_LOCAL_OP = 8'h17;
    localparam logic [7:0] FC_LOCAL_REF = 8'h18;
    localparam logic [7:0] FC_LOW_TORQUE = 8'h19;
    localparam logic [7:0] FC_REF_LOSS = 8'h1a;
    localparam logic [7:0] FC_TIMER = 8'h1b;
    localparam logic [7:0] FC_FDET3 = 8'h32;
    localparam logic [7:0] FC_FDET4 = 8'h33;
    localparam logic [7:0] FC_FDET5 = 8'h34;
    localparam logic [7:0] FC_FDET6 = 8'h35;
    localparam logic [7:0] FC_LOW_CUR = 8'h39;

    // fault codes that must not close the fault contact (values arbitrary)
    localparam logic [7:0] COMM_ERROR_CODE_A = 8'h41;
    localparam logic [7:0] COMM_ERROR_CODE_B = 8'h42;

    // command source value that selects the local operator
    localparam logic [1:0] SRC_LOCAL = 2'h0;

    // reference loss actions
    localparam logic LOSS_DECEL = 1'b0;
    localparam logic LOSS_CONTINUE = 1'b1;
    localparam int RATIO_FULL = 100;

    // timing: timer and duration settings count in 0.1 s steps
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIME_UNIT_NS = 100000000;
    localparam int TICK_CYCLES_DOC = TIME_UNIT_NS / CLK_PERIOD_NS;

    // frequency detector indices
    localparam int DET_1 = 0;
    localparam int DET_2 = 1;
    localparam int DET_3 = 2;
    localparam int N_DET = 3;

    // timer function states
    typedef enum logic [1:0] {
        MFOS_TMR_IDLE,
        MFOS_TMR_ON_WAIT,
        MFOS_TMR_ON,
        MFOS_TMR_OFF_WAIT
    } mfos_tmr_t;

endpackage

/* rtl/mfos_hyst.sv */
// frequency level detector with hysteresis
`timescale 1ns/1ps
module mfos_hyst
    import mfos_pkg::*;
#(
    parameter int FW = 16
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [FW-1:0] freq,
    input wire logic [FW-1:0] level,
    input wire logic [FW-1:0] width,
    output logic above
);

    logic [FW:0] upper;
    logic next_above;

    assign upper = {1'b0, level} + {1'b0, width};

    // set above level plus width, release only below level
    always_comb
    begin
        next_above = above;
        if ({1'b0, freq} > upper)
        begin
            next_above = 1'b1;
        end
        else if (freq < level)
        begin
            next_above = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            above <= 1'b0;
        end
        else
        begin
            above <= next_above;
        end
    end

endmodule

/* rtl/mfos_top.sv */
// multi-function digital output selector of a motor drive
`timescale 1ns/1ps
module mfos_top
    import mfos_pkg::*;
#(
    parameter int N_OUT = 3,
    parameter int FW = 16,
    parameter int CW = 16,
    parameter int VW = 16,
    parameter int TW = 8,
    parameter int TICK_CYCLES = TICK_CYCLES_DOC
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [N_OUT*8-1:0] output_function_select,
    input wire logic run_cmd,
    input wire logic [FW-1:0] out_freq,
    input wire logic [FW-1:0] freq_ref,
    input wire logic fault_active,
    input wire logic [7:0] fault_code,
    input wire logic drive_ready,
    input wire logic restart_active,
    input wire logic output_block,
    input wire logic over_torque,
    input wire logic low_torque,
    input wire logic [CW-1:0] out_current,
    input wire logic [VW-1:0] dc_bus_volt,
    input wire logic ref_lost,
    input wire logic [FW-1:0] det_level_1,
    input wire logic [FW-1:0] det_width_1,
    input wire logic [FW-1:0] det_level_2,
    input wire logic [FW-1:0] det_width_2,
    input wire logic [FW-1:0] det_level_3,
    input wire logic [FW-1:0] det_width_3,
    input wire logic [FW-1:0] min_freq,
    input wire logic [CW-1:0] cur_agree_level,
    input wire logic [TW-1:0] cur_agree_time,
    input wire logic [CW-1:0] low_cur_level,
    input wire logic [VW-1:0] low_volt_level,
    input wire logic [1:0] op_cmd_src,
    input wire logic [1:0] freq_cmd_src,
    input wire logic local_remote_pin,
    input wire logic timer_pin,
    input wire logic [TW-1:0] timer_on_delay,
    input wire logic [TW-1:0] timer_off_delay,
    input wire logic loss_action,
    input wire logic [7:0] loss_ratio,
    output logic [N_OUT-1:0] out_term,
    output logic ref_loss_decel,
    output logic [FW-1:0] ref_loss_freq
);

    // pin synchronisers
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] next_pin_meta;
    logic [1:0] next_pin_sync;
    logic local_sel;
    logic timer_in;

    always_comb
    begin
        next_pin_meta = {timer_pin, local_remote_pin};
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end
        else
        begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    assign local_sel = pin_sync[0];
    assign timer_in = pin_sync[1];

    // 0.1 s tick
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic tick;
    logic next_tick;

    always_comb
    begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + 32'h1;
        if (tick_cnt >= 32'(TICK_CYCLES - 1))
        begin
            next_tick_cnt = 32'h0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    // current agree: current above threshold longer than duration
    logic [TW:0] cur_cnt;
    logic [TW:0] next_cur_cnt;
    logic cur_agree;
    logic next_cur_agree;

    always_comb
    begin
        next_cur_cnt = cur_cnt;
        next_cur_agree = cur_agree;
        if (out_current <= cur_agree_level)
        begin
            next_cur_cnt = '0;
            next_cur_agree = 1'b0;
        end
        else
        begin
            if (tick && (cur_cnt <= {1'b0, cur_agree_time}))
            begin
                next_cur_cnt = cur_cnt + 1'b1;
            end
            next_cur_agree = (cur_cnt > {1'b0, cur_agree_time});
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur_cnt <= '0;
            cur_agree <= 1'b0;
        end
        else
        begin
            cur_cnt <= next_cur_cnt;
            cur_agree <= next_cur_agree;
        end
    end

    // timer function: on-delay then off-delay, in ticks
    mfos_tmr_t tmr_state;
    mfos_tmr_t next_tmr_state;
    logic [TW-1:0] tmr_cnt;
    logic [TW-1:0] next_tmr_cnt;
    logic timer_out;

    always_comb
    begin
        next_tmr_state = tmr_state;
        next_tmr_cnt = tmr_cnt;
        case (tmr_state)
            MFOS_TMR_IDLE:
            begin
                next_tmr_cnt = '0;
                if (timer_in)
                begin
                    next_tmr_state = MFOS_TMR_ON_WAIT;
                end
            end
            MFOS_TMR_ON_WAIT:
            begin
                if (!timer_in)
                begin
                    next_tmr_state = MFOS_TMR_IDLE;
                end
                else if (tmr_cnt >= timer_on_delay)
                begin
                    next_tmr_state = MFOS_TMR_ON;
                    next_tmr_cnt = '0;
                end
                else if (tick)
                begin
                    next_tmr_cnt = tmr_cnt + 1'b1;
                end
            end
            MFOS_TMR_ON:
            begin
                next_tmr_cnt = '0;
                if (!timer_in)
                begin
                    next_tmr_state = MFOS_TMR_OFF_WAIT;
                end
            end
            MFOS_TMR_OFF_WAIT:
            begin
                if (timer_in)
                begin
                    next_tmr_state = MFOS_TMR_ON;
                end
                else if (tmr_cnt >= timer_off_delay)
                begin
                    next_tmr_state = MFOS_TMR_IDLE;
                end
                else if (tick)
                begin
                    next_tmr_cnt = tmr_cnt + 1'b1;
                end
            end
            default:
            begin
                next_tmr_state = MFOS_TMR_IDLE;
                next_tmr_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tmr_state <= MFOS_TMR_IDLE;
            tmr_cnt <= '0;
        end
        else
        begin
            tmr_state <= next_tmr_state;
            tmr_cnt <= next_tmr_cnt;
        end
    end

    assign timer_out = (tmr_state == MFOS_TMR_ON) ||
        (tmr_state == MFOS_TMR_OFF_WAIT);

    // hysteresis detectors for the three level sets
    logic [FW-1:0] det_level [N_DET];
    logic [FW-1:0] det_width [N_DET];
    logic [N_DET-1:0] det_above;

    assign det_level[DET_1] = det_level_1;
    assign det_width[DET_1] = det_width_1;
    assign det_level[DET_2] = det_level_2;
    assign det_width[DET_2] = det_width_2;
    assign det_level[DET_3] = det_level_3;
    assign det_width[DET_3] = det_width_3;

    genvar d;
    generate
        for (d = 0; d < N_DET; d++)
        begin : g_det
            mfos_hyst #(
                .FW(FW)
            ) u_hyst (
                .mclk(mclk),
                .rst_b(rst_b),
                .freq(out_freq),
                .level(det_level[d]),
                .width(det_width[d]),
                .above(det_above[d])
            );
        end
    endgenerate

    // window comparisons
    logic [FW:0] ref_hi;
    logic [FW:0] ref_lo;
    logic [FW:0] lvl_hi;
    logic [FW:0] lvl_lo;
    logic freq_agree;
    logic set_agree;

    assign ref_hi = {1'b0, freq_ref} + {1'b0, det_width_1};
    assign ref_lo = {1'b0, freq_ref} - {1'b0, det_width_1};
    assign lvl_hi = {1'b0, det_level_1} + {1'b0, det_width_1};
    assign lvl_lo = {1'b0, det_level_1} - {1'b0, det_width_1};
    // a negative lower bound wraps into the top bit and counts as zero
    assign freq_agree = (ref_lo[FW] || ({1'b0, out_freq} >= ref_lo)) &&
        ({1'b0, out_freq} <= ref_hi);
    assign set_agree = (lvl_lo[FW] || ({1'b0, out_freq} >= lvl_lo)) &&
        ({1'b0, out_freq} <= lvl_hi);

    // reference loss action and last valid reference
    logic [FW-1:0] last_ref;
    logic [FW-1:0] next_last_ref;
    logic next_ref_loss_decel;
    logic [FW-1:0] next_ref_loss_freq;
    logic [FW+7:0] scaled_ref;

    assign scaled_ref = (FW+8)'(({8'h0, last_ref} * {{FW{1'b0}}, loss_ratio})
        / (FW+8)'(RATIO_FULL));

    always_comb
    begin
        next_last_ref = ref_lost ? last_ref : freq_ref;
        next_ref_loss_decel = ref_lost && (loss_action == LOSS_DECEL);
        next_ref_loss_freq = freq_ref;
        if (ref_lost)
        begin
            if (loss_action == LOSS_CONTINUE)
            begin
                next_ref_loss_freq = scaled_ref[FW-1:0];
            end
            else
            begin
                next_ref_loss_freq = '0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            last_ref <= '0;
            ref_loss_decel <= 1'b0;
            ref_loss_freq <= '0;
        end
        else
        begin
            last_ref <= next_last_ref;
            ref_loss_decel <= next_ref_loss_decel;
            ref_loss_freq <= next_ref_loss_freq;
        end
    end

    // per-terminal function selection
    wire logic [N_OUT-1:0] next_out_term;
    logic comm_fault;

    assign comm_fault = (fault_code == COMM_ERROR_CODE_A) ||
        (fault_code == COMM_ERROR_CODE_B);

    genvar g;
    generate
        for (g = 0; g < N_OUT; g++)
        begin : g_out
            logic [7:0] code;
            logic sel;

            assign code = output_function_select[g*8 +: 8];

            always_comb
            begin
                case (code)
                    FC_RUNNING: sel = run_cmd || (out_freq != '0);
                    FC_FAULT: sel = fault_active && !comm_fault;
                    FC_FREQ_AGREE: sel = freq_agree;
                    FC_SET_AGREE: sel = set_agree;
                    FC_FDET1: sel = det_above[DET_1];
                    FC_FDET2: sel = !det_above[DET_1];
                    FC_RESTART: sel = restart_active;
                    FC_OUT_BLOCK: sel = output_block;
                    FC_OVER_TORQUE: sel = over_torque;
                    FC_LOW_TORQUE: sel = low_torque;
                    FC_CUR_AGREE: sel = cur_agree;
                    FC_ZERO_SPEED: sel = out_freq <= min_freq;
                    FC_READY: sel = drive_ready && !fault_active;
                    FC_UNDERVOLT: sel = dc_bus_volt < low_volt_level;
                    FC_LOCAL_OP:
                        sel = (op_cmd_src == SRC_LOCAL) || local_sel;
                    FC_LOCAL_REF:
                        sel = (freq_cmd_src == SRC_LOCAL) || local_sel;
                    FC_REF_LOSS: sel = ref_lost;
                    FC_TIMER: sel = timer_out;
                    FC_FDET3: sel = det_above[DET_2];
                    FC_FDET4: sel = !det_above[DET_2];
                    FC_FDET5: sel = det_above[DET_3];
                    FC_FDET6: sel = !det_above[DET_3];
                    FC_LOW_CUR: sel = out_current <= low_cur_level;
                    default: sel = 1'b0;
                endcase
            end

            assign next_out_term[g] = sel;
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_term <= '0;
        end
        else
        begin
            out_term <= next_out_term;
        end
    end

endmodule

/* sim/mfos_relay_load.sv */
// relay coils and contacts of the external equipment
`timescale 1ns/1ps
module mfos_relay_load
#(
    parameter int N = 3
)
(
    input wire logic [N-1:0] coil,
    output logic [N-1:0] contact
);
    // normally open contact closes while its coil is energised
    assign contact = coil;
endmodule

/* sim/mfos_top_sva.sv */
// assertions on the ports of the output selector
`timescale 1ns/1ps
module mfos_top_sva
    import mfos_pkg::*;
#(
    parameter int N_OUT = 3,
    parameter int FW = 16,
    parameter int CW = 16,
    parameter int VW = 16
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [N_OUT*8-1:0] output_function_select,
    input wire logic run_cmd,
    input wire logic [FW-1:0] out_freq,
    input wire logic fault_active,
    input wire logic [7:0] fault_code,
    input wire logic [FW-1:0] min_freq,
    input wire logic [VW-1:0] dc_bus_volt,
    input wire logic [VW-1:0] low_volt_level,
    input wire logic [CW-1:0] out_current,
    input wire logic [CW-1:0] low_cur_level,
    input wire logic ref_lost,
    input wire logic loss_action,
    input wire logic [FW-1:0] det_level_1,
    input wire logic [FW-1:0] det_width_1,
    input wire logic [FW-1:0] det_level_3,
    input wire logic [N_OUT-1:0] out_term,
    input wire logic ref_loss_decel
);
    logic [7:0] sel0;
    logic [7:0] sel1;
    assign sel0 = output_function_select[7:0];
    assign sel1 = output_function_select[15:8];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // detector needs two cycles of a steady condition
    sequence s_over1;
        (sel0 == FC_FDET1 && out_freq > 17'(det_level_1) + 17'(det_width_1)) [*2];
    endsequence
    sequence s_under1;
        (sel0 == FC_FDET1 && out_freq < det_level_1) [*2];
    endsequence
    sequence s_under3;
        (sel1 == FC_FDET6 && out_freq < det_level_3) [*2];
    endsequence
    chk_run_state: assert property (
        sel0 == FC_RUNNING |=>
        out_term[0] == ($past(run_cmd) || $past(out_freq) != 0))
        else $error("running output wrong");
    chk_fault_contact: assert property (
        sel0 == FC_FAULT |=> out_term[0] == ($past(fault_active) &&
        $past(fault_code) != COMM_ERROR_CODE_A &&
        $past(fault_code) != COMM_ERROR_CODE_B))
        else $error("fault output wrong");
    chk_zero_speed: assert property (
        sel0 == FC_ZERO_SPEED |=>
        out_term[0] == ($past(out_freq) <= $past(min_freq)))
        else $error("zero speed output wrong");
    chk_under_volt: assert property (
        sel0 == FC_UNDERVOLT |=>
        out_term[0] == ($past(dc_bus_volt) < $past(low_volt_level)))
        else $error("undervoltage output wrong");
    chk_low_current: assert property (
        sel0 == FC_LOW_CUR |=>
        out_term[0] == ($past(out_current) <= $past(low_cur_level)))
        else $error("low current output wrong");
    chk_loss_decel: assert property (
        ##1 ref_loss_decel == ($past(ref_lost) && !$past(loss_action)))
        else $error("loss decel flag wrong");
    chk_hyst_set: assert property (s_over1 |=> out_term[0])
        else $error("detector did not set");
    chk_hyst_clear: assert property (s_under1 |=> !out_term[0])
        else $error("detector did not clear");
    chk_inv_detect: assert property (s_under3 |=> out_term[1])
        else $error("inverse detector wrong");
endmodule
bind mfos_top mfos_top_sva #(.N_OUT(N_OUT), .FW(FW), .CW(CW), .VW(VW)) u_sva (
    .mclk, .rst_b, .output_function_select, .run_cmd, .out_freq,
    .fault_active, .fault_code, .min_freq, .dc_bus_volt, .low_volt_level,
    .out_current, .low_cur_level, .ref_lost, .loss_action, .det_level_1,
    .det_width_1, .det_level_3, .out_term, .ref_loss_decel);

/* sim/testbench.sv */
// self-checking bench for the output selector
`timescale 1ns/1ps
module testbench;
    import mfos_pkg::*;
    logic mclk = 0, rst_b = 0, run_cmd = 1, fault_active = 0, drive_ready = 0;
    logic restart_active = 0, output_block = 0, over_torque = 0;
    logic low_torque = 0, ref_lost = 0, local_remote_pin = 0, timer_pin = 0;
    logic loss_action = 0;
    logic [23:0] output_function_select = 24'h070000;
    logic [15:0] out_freq = '0, freq_ref = '0, out_current = '0, min_freq = '0;
    logic [15:0] dc_bus_volt = '0, det_level_1 = '0, det_width_1 = '0;
    logic [15:0] det_level_2 = '0, det_width_2 = '0, det_level_3 = '0;
    logic [15:0] det_width_3 = '0, cur_agree_level = '0, low_cur_level = '0;
    logic [15:0] low_volt_level = '0, ref_loss_freq;
    logic [7:0] fault_code = '0, cur_agree_time = '0, timer_on_delay = '0;
    logic [7:0] timer_off_delay = '0, loss_ratio = '0;
    logic [1:0] op_cmd_src = '0, freq_cmd_src = '0;
    logic [2:0] out_term, contact;
    logic ref_loss_decel;
    int n_errors = 0, samples_checked = 0;
    logic [7:0] flag_codes [5] = '{8'h06, 8'h09, 8'h0c, 8'h19, 8'h1a};
    logic [15:0] sweep [5] = '{16'h0000, 16'h0069, 16'h006f, 16'h0069, 16'h0063};
    logic [15:0] pair_codes [3] = '{16'h0504, 16'h3332, 16'h3534};

    mfos_top #(.TICK_CYCLES(4)) DUT (.mclk, .rst_b, .output_function_select,
        .run_cmd, .out_freq, .freq_ref, .fault_active, .fault_code,
        .drive_ready, .restart_active, .output_block, .over_torque,
        .low_torque, .out_current, .dc_bus_volt, .ref_lost, .det_level_1,
        .det_width_1, .det_level_2, .det_width_2, .det_level_3, .det_width_3,
        .min_freq, .cur_agree_level, .cur_agree_time, .low_cur_level,
        .low_volt_level, .op_cmd_src, .freq_cmd_src, .local_remote_pin,
        .timer_pin, .timer_on_delay, .timer_off_delay, .loss_action,
        .loss_ratio, .out_term, .ref_loss_decel, .ref_loss_freq);
    mfos_relay_load #(.N(3)) u_load (.coil(out_term), .contact(contact));

    always #5 mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sel(input logic [7:0] c0, input logic [7:0] c1);
        @(posedge mclk);
        output_function_select <= {8'h07, c1, c0};
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        wt(5);
        check(out_term, 3'h0);
        @(posedge mclk);
        rst_b <= 1'b1;
        wt(3);
        check(contact, 3'h3);
        @(posedge mclk);
        run_cmd <= 1'b0;
        out_freq <= 16'h0005;
        wt(3);
        check(contact[0], 1'b1);
        @(posedge mclk);
        out_freq <= 16'h0000;
        wt(3);
        check(contact[0], 1'b0);
        $display("test run done");
        sel(8'h01, 8'h15);
        @(posedge mclk);
        fault_active <= 1'b1;
        fault_code <= 8'h10;
        drive_ready <= 1'b1;
        wt(3);
        check(contact, 3'h1);
        @(posedge mclk);
        fault_code <= COMM_ERROR_CODE_A;
        wt(3);
        check(contact[0], 1'b0);
        @(posedge mclk);
        fault_code <= COMM_ERROR_CODE_B;
        wt(3);
        check(contact[0], 1'b0);
        @(posedge mclk);
        fault_active <= 1'b0;
        wt(3);
        check(contact, 3'h2);
        for (int i = 0; i < 5; i++)
        begin
            sel(flag_codes[i], 8'h15);
            @(posedge mclk);
            {ref_lost, low_torque, over_torque, output_block, restart_active}
                <= 5'h01 << i;
            wt(3);
            check(contact, 3'h3);
        end
        @(posedge mclk);
        ref_lost <= 1'b0;
        wt(3);
        check(contact, 3'h2);
        $display("test flags done");
        sel(8'h39, 8'h14);
        @(posedge mclk);
        min_freq <= 16'h0064;
        out_freq <= 16'h0064;
        low_cur_level <= 16'h0032;
        out_current <= 16'h0032;
        wt(3);
        check(contact, 3'h3);
        @(posedge mclk);
        out_freq <= 16'h0065;
        out_current <= 16'h0033;
        wt(3);
        check(contact, 3'h0);
        sel(8'h16, 8'h02);
        @(posedge mclk);
        low_volt_level <= 16'h012c;
        dc_bus_volt <= 16'h012b;
        freq_ref <= 16'h00c8;
        det_width_1 <= 16'h000a;
        out_freq <= 16'h00be;
        wt(3);
        check(contact, 3'h3);
        @(posedge mclk);
        dc_bus_volt <= 16'h012c;
        out_freq <= 16'h00bd;
        wt(3);
        check(contact, 3'h0);
        sel(8'h03, 8'h02);
        @(posedge mclk);
        det_level_1 <= 16'h00c8;
        out_freq <= 16'h00d2;
        wt(3);
        check(contact, 3'h3);
        @(posedge mclk);
        out_freq <= 16'h00d3;
        wt(3);
        check(contact, 3'h0);
        $display("test levels done");
        @(posedge mclk);
        {det_level_1, det_level_2, det_level_3} <= {3{16'h0064}};
        {det_width_1, det_width_2, det_width_3} <= {3{16'h000a}};
        for (int p = 0; p < 3; p++)
        begin
            sel(pair_codes[p][7:0], pair_codes[p][15:8]);
            for (int k = 0; k < 5; k++)
            begin
                @(posedge mclk);
                out_freq <= sweep[k];
                wt(4);
                check(contact[1:0], {~k[1], k[1]} & {2{k != 0}} |
                    {k == 0, 1'b0});
            end
        end
        $display("test detectors done");
        sel(8'h17, 8'h18);
        @(posedge mclk);
        freq_cmd_src <= 2'h1;
        wt(6);
        check(contact, 3'h1);
        @(posedge mclk);
        local_remote_pin <= 1'b1;
        wt(6);
        check(contact, 3'h3);
        @(posedge mclk);
        local_remote_pin <= 1'b0;
        op_cmd_src <= 2'h2;
        freq_cmd_src <= 2'h0;
        wt(6);
        check(contact, 3'h2);
        $display("test local done");
        sel(8'h0d, 8'h1b);
        @(posedge mclk);
        cur_agree_level <= 16'h0064;
        cur_agree_time <= 8'h02;
        out_current <= 16'h0065;
        timer_on_delay <= 8'h02;
        timer_off_delay <= 8'h02;
        timer_pin <= 1'b1;
        wt(4);
        check(contact, 3'h0);
        wt(20);
        check(contact, 3'h3);
        @(posedge mclk);
        out_current <= 16'h0064;
        timer_pin <= 1'b0;
        wt(4);
        check(contact, 3'h2);
        wt(20);
        check(contact, 3'h0);
        $display("test timed done");
        sel(8'h1a, 8'h1a);
        @(posedge mclk);
        loss_ratio <= 8'h32;
        wt(3);
        check(ref_loss_freq, 16'h00c8);
        @(posedge mclk);
        ref_lost <= 1'b1;
        freq_ref <= 16'h012c;
        wt(3);
        check({contact, ref_loss_decel, ref_loss_freq}, 32'h70000);
        check(ref_loss_decel, 1'b1);
        @(posedge mclk);
        loss_action <= 1'b1;
        wt(3);
        check({ref_loss_decel, ref_loss_freq}, 32'h00064);
        $display("test loss done");
        summarize();
    end

    initial
    begin
        repeat (3000) @(posedge mclk);
        n_errors++;
        summarize();
    end
endmodule
